//--- design/interrupt_enable_flag_logic.sv
`timescale 1ns/100ps
// Behaviour
// - Primary enable register, one bit per source
// - Wake enable bit also runs wake timer
// - Global enable reset one, other secondaries zero
// - Conversion end sets conversion flag
// - Writing zero clears flag, one ignored
// - Base timer overflow sets its flag
// - Eight-bit timer overflows set their flags
// - Wake timeout sets wake flag
// - Falling edge on pin two sets flag
// - Pins one, zero edge sets flags
// - Polarity bits pick edge, reset falling
// - Serial flag read-only, follows tx/rx done
// - Pulse period rollover sets pulse flag
// - Low supply level sets its flag
module interrupt_enable_flag_logic (
  // System clock
  input wire logic mclk,
  // Synchronous reset, active low
  input wire logic rst_n,
  // Register address
  input wire logic [8:0] reg_addr,
  // Register write data
  input wire logic [7:0] reg_wdata,
  // Write strobe, one cycle
  input wire logic reg_wr,
  // Read strobe, one cycle
  input wire logic reg_rd,
  // Read data, cycle after strobe
  output logic [7:0] reg_rdata,
  // Conversion end strobe
  input wire logic conv_end,
  // Base timer overflow strobe
  input wire logic base_timer_ovf,
  // Second eight-bit timer overflow
  input wire logic second_timer_ovf,
  // First eight-bit timer overflow
  input wire logic first_timer_ovf,
  // Wake timer period timeout
  input wire logic wake_timeout,
  // External pin two, asynchronous
  input wire logic ext_pin_two,
  // External pin one, asynchronous
  input wire logic ext_pin_one,
  // External pin zero, asynchronous
  input wire logic ext_pin_zero,
  // Serial transmit done level
  input wire logic serial_tx_done,
  // Serial receive done level
  input wire logic serial_rx_done,
  // Pulse period rollover strobe
  input wire logic pulse_rollover,
  // Low supply level
  input wire logic supply_low,
  // Wake timer run enable
  output logic wake_timer_run,
  // Request level to the core
  output logic cpu_irq_req,
  // Raw status level gated by the raw mask register
  output logic raw_irq
);

  // Register contents
  logic [7:0] en_pri_q;
  logic [7:0] flag_pri_q;
  logic [7:0] en_sec_q;
  logic [7:0] flag_sec_q;
  logic [7:0] option_q;
  logic [7:0] raw_stat_q;
  logic [7:0] raw_mask_q;
  logic [7:0] rdata_q;
  // Pin synchronisers and previous levels
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic [2:0] pin_prev_q;
  // Event vectors
  logic [7:0] set_pri;
  logic [7:0] set_sec;
  logic fall2;
  logic edge1;
  logic edge0;
  logic serial_pend;

  // Address match for one offset, write strobe gated by the caller
  function automatic logic hit(input logic [8:0] a, input logic [8:0] off);
    hit = (a == off);
  endfunction

  // Edge detect honouring selected polarity
  function automatic logic pin_edge(input logic now, input logic prev,
                                    input logic rising);
    pin_edge = rising ? (now & ~prev) : (~now & prev);
  endfunction

  // Clear-by-zero with set priority
  function automatic logic [7:0] flag_next(input logic [7:0] cur,
                                           input logic [7:0] setv,
                                           input logic wr,
                                           input logic [7:0] wd,
                                           input logic [7:0] mask);
    logic [7:0] keep;
    keep = wr ? (cur & (wd | ~mask)) : cur;
    flag_next = keep | setv;
  endfunction

  // Pin synchroniser, two stages then history
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_meta_q <= 3'h7;
      pin_sync_q <= 3'h7;
      pin_prev_q <= 3'h7;
    end else begin
      pin_meta_q <= {ext_pin_two, ext_pin_one, ext_pin_zero};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  assign fall2 = pin_edge(pin_sync_q[2], pin_prev_q[2], 1'b0);
  // pins one and zero by polarity
  assign edge1 = pin_edge(pin_sync_q[1], pin_prev_q[1],
                          option_q[irq_flags_pkg::B_POL1]);
  assign edge0 = pin_edge(pin_sync_q[0], pin_prev_q[0],
                          option_q[irq_flags_pkg::B_POL0]);

  // Primary event vector
  always_comb begin
    set_pri = irq_flags_pkg::ZERO8;
    set_pri[irq_flags_pkg::B_CONV] = conv_end;
    set_pri[irq_flags_pkg::B_BASE] = base_timer_ovf;
    set_pri[irq_flags_pkg::B_SECOND] = second_timer_ovf;
    set_pri[irq_flags_pkg::B_FIRST] = first_timer_ovf;
    set_pri[irq_flags_pkg::B_WAKE] = wake_timeout;
    set_pri[irq_flags_pkg::B_PIN2] = fall2;
    set_pri[irq_flags_pkg::B_PIN1] = edge1;
    set_pri[irq_flags_pkg::B_PIN0] = edge0;
  end

  assign serial_pend = serial_tx_done | serial_rx_done;

  // Secondary event vector
  always_comb begin
    set_sec = irq_flags_pkg::ZERO8;
    set_sec[irq_flags_pkg::B_PULSE] = pulse_rollover;
    set_sec[irq_flags_pkg::B_LOWSUP] = supply_low;
  end

  // Enable registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      en_pri_q <= irq_flags_pkg::RST_EN_PRI;
      en_sec_q <= irq_flags_pkg::RST_EN_SEC;
    end else if (reg_wr) begin
      if (hit(reg_addr, irq_flags_pkg::OFF_EN_PRI)) begin
        en_pri_q <= reg_wdata;
      end
      if (hit(reg_addr, irq_flags_pkg::OFF_EN_SEC)) begin
        en_sec_q <= reg_wdata & irq_flags_pkg::SEC_EN_MASK;
      end
    end
  end

  // Option polarity register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      option_q <= irq_flags_pkg::RST_OPTION;
    end else if (reg_wr && hit(reg_addr, irq_flags_pkg::OFF_OPTION)) begin
      option_q <= reg_wdata & irq_flags_pkg::OPT_MASK;
    end
  end

  // Pending flag registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flag_pri_q <= irq_flags_pkg::RST_FLAGS;
      flag_sec_q <= irq_flags_pkg::RST_FLAGS;
    end else begin
      flag_pri_q <= flag_next(flag_pri_q, set_pri,
        reg_wr && hit(reg_addr, irq_flags_pkg::OFF_FLAG_PRI),
        reg_wdata, ~irq_flags_pkg::ZERO8);
      flag_sec_q <= flag_next(flag_sec_q & irq_flags_pkg::SEC_CLR_MASK,
        set_sec,
        reg_wr && hit(reg_addr, irq_flags_pkg::OFF_FLAG_SEC),
        reg_wdata, irq_flags_pkg::SEC_CLR_MASK);
    end
  end

  // Raw status, write one to clear, set wins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      raw_stat_q <= irq_flags_pkg::RST_FLAGS;
      raw_mask_q <= irq_flags_pkg::RST_FLAGS;
    end else begin
      if (reg_wr && hit(reg_addr, irq_flags_pkg::OFF_RAW_STAT)) begin
        raw_stat_q <= (raw_stat_q & ~reg_wdata) | set_pri;
      end else begin
        raw_stat_q <= raw_stat_q | set_pri;
      end
      if (reg_wr && hit(reg_addr, irq_flags_pkg::OFF_RAW_MASK)) begin
        raw_mask_q <= reg_wdata;
      end
    end
  end

  // Read data, one cycle after strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_q <= irq_flags_pkg::ZERO8;
    end else if (reg_rd) begin
      unique case (reg_addr)
        irq_flags_pkg::OFF_EN_PRI: rdata_q <= en_pri_q;
        irq_flags_pkg::OFF_FLAG_PRI: rdata_q <= flag_pri_q;
        irq_flags_pkg::OFF_EN_SEC: rdata_q <= en_sec_q;
        // serial bit shows live done state
        irq_flags_pkg::OFF_FLAG_SEC: rdata_q <= flag_sec_q
          | ({7'h00, serial_pend} << irq_flags_pkg::B_SERIAL);
        irq_flags_pkg::OFF_OPTION: rdata_q <= option_q;
        irq_flags_pkg::OFF_RAW_STAT: rdata_q <= raw_stat_q;
        irq_flags_pkg::OFF_RAW_MASK: rdata_q <= raw_mask_q;
        // Unmapped reads as zero
        default: rdata_q <= irq_flags_pkg::ZERO8;
      endcase
    end else begin
      rdata_q <= irq_flags_pkg::ZERO8;
    end
  end

  assign reg_rdata = rdata_q;

  assign wake_timer_run = en_pri_q[irq_flags_pkg::B_WAKE];

  assign cpu_irq_req = en_sec_q[irq_flags_pkg::B_GLOBAL] &
    (|(flag_pri_q & en_pri_q) |
     |({flag_sec_q[7:1], flag_sec_q[0]} & en_sec_q
       & irq_flags_pkg::SEC_CLR_MASK) |
     (serial_pend & en_sec_q[irq_flags_pkg::B_SERIAL]));

  // Raw interrupt, sticky status gated by raw mask
  assign raw_irq = |(raw_stat_q & raw_mask_q);

endmodule // interrupt_enable_flag_logic

//--- design/irq_flags_pkg.sv
package irq_flags_pkg;
  // Register offsets on the 9-bit register port
  localparam logic [8:0] OFF_EN_PRI = 9'h00b;
  localparam logic [8:0] OFF_FLAG_PRI = 9'h00c;
  localparam logic [8:0] OFF_EN_SEC = 9'h00d;
  localparam logic [8:0] OFF_FLAG_SEC = 9'h00e;
  localparam logic [8:0] OFF_OPTION = 9'h081;
  localparam logic [8:0] OFF_RAW_STAT = 9'h1f0;
  localparam logic [8:0] OFF_RAW_MASK = 9'h1f1;
  // Primary enable and flag bit positions
  localparam int B_CONV = 7;
  localparam int B_BASE = 6;
  localparam int B_SECOND = 5;
  localparam int B_FIRST = 4;
  localparam int B_WAKE = 3;
  localparam int B_PIN2 = 2;
  localparam int B_PIN1 = 1;
  localparam int B_PIN0 = 0;
  // Secondary enable and flag bit positions
  localparam int B_GLOBAL = 7;
  localparam int B_SERIAL = 6;
  localparam int B_PULSE = 1;
  localparam int B_LOWSUP = 0;
  // Option register polarity positions
  localparam int B_POL0 = 6;
  localparam int B_POL1 = 5;
  // Reset values
  localparam logic [7:0] RST_EN_PRI = 8'h00;
  localparam logic [7:0] RST_EN_SEC = 8'h80;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_OPTION = 8'h00;
  // Implemented bit masks
  localparam logic [7:0] SEC_EN_MASK = 8'hc3;
  localparam logic [7:0] SEC_FLAG_MASK = 8'h43;
  localparam logic [7:0] SEC_CLR_MASK = 8'h03;
  localparam logic [7:0] OPT_MASK = 8'h60;
  localparam logic [7:0] ZERO8 = 8'h00;
endpackage : irq_flags_pkg

//--- testbench/irq_flags_assertions.sv
`timescale 1ns/100ps
// Port-level checks for the flag and enable block
module irq_flags_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic conv_end,
  input wire logic pulse_rollover,
  input wire logic supply_low,
  input wire logic wake_timer_run,
  input wire logic cpu_irq_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Quiet cycle, then a primary flag read
  sequence flag_rd_next;
    !reg_wr ##1 reg_rd && reg_addr == irq_flags_pkg::OFF_FLAG_PRI;
  endsequence
  // Clear-by-zero write on the conversion flag during its event
  sequence conv_clash;
    conv_end && reg_wr && reg_addr == irq_flags_pkg::OFF_FLAG_PRI &&
      !reg_wdata[7];
  endsequence
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  conv_set_a: assert property (
    conv_end ##1 flag_rd_next |=> reg_rdata[7])
    else $error("conversion flag missing");
  set_wins_a: assert property (
    conv_clash ##1 flag_rd_next |=> reg_rdata[7])
    else $error("clear beat the set");
  pulse_set_a: assert property (pulse_rollover ##1 reg_rd &&
    reg_addr == irq_flags_pkg::OFF_FLAG_SEC |=> reg_rdata[1])
    else $error("pulse flag missing");
  low_set_a: assert property (supply_low ##1 reg_rd &&
    reg_addr == irq_flags_pkg::OFF_FLAG_SEC |=> reg_rdata[0])
    else $error("low supply flag missing");
  wake_run_a: assert property (reg_wr &&
    reg_addr == irq_flags_pkg::OFF_EN_PRI |=>
    wake_timer_run == $past(reg_wdata[3])) else $error("wake run wrong");
  global_off_a: assert property (reg_wr &&
    reg_addr == irq_flags_pkg::OFF_EN_SEC && !reg_wdata[7] |=> !cpu_irq_req)
    else $error("request without global enable");
  sec_bits_a: assert property (reg_rd &&
    reg_addr == irq_flags_pkg::OFF_EN_SEC |=>
    (reg_rdata & ~irq_flags_pkg::SEC_EN_MASK) == 8'h00)
    else $error("unused enable bit set");
endmodule // irq_flags_checker

bind interrupt_enable_flag_logic irq_flags_checker chk (.*);

//--- testbench/cpu_core_model.sv
`timescale 1ns/100ps
// Core side: samples the request level as its fetch logic would
module cpu_core_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cpu_irq_req,
  output logic irq_taken_q
);
  always_ff @(posedge mclk) begin
    irq_taken_q <= rst_n && cpu_irq_req;
  end
endmodule // cpu_core_model

//--- testbench/tb_interrupt_enable_flag_logic.sv
`timescale 1ns/100ps
// Self-checking bench for the flag and enable block
module tb_interrupt_enable_flag_logic;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] reg_addr = 9'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] ev = 8'h07; // Event strobes, pins idle high
  logic [3:0] sv = 4'h0; // Tx, rx, rollover, low supply
  logic wake_timer_run;
  logic cpu_irq_req;
  logic raw_irq;
  logic irq_taken_q;
  logic rd_seen = 1'b0; // Strobe taken last edge
  logic [7:0] exp_q[$]; // Expected read data, oldest first
  logic [7:0] r;
  int seed = 32'h3cf3;
  int n_mismatch = 0;
  int n_compared = 0;
  // Clock
  always #5 mclk = ~mclk;
  interrupt_enable_flag_logic dut (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_end(ev[7]),
    .base_timer_ovf(ev[6]), .second_timer_ovf(ev[5]),
    .first_timer_ovf(ev[4]), .wake_timeout(ev[3]), .ext_pin_two(ev[2]),
    .ext_pin_one(ev[1]), .ext_pin_zero(ev[0]), .serial_tx_done(sv[3]),
    .serial_rx_done(sv[2]), .pulse_rollover(sv[1]), .supply_low(sv[0]),
    .wake_timer_run(wake_timer_run), .cpu_irq_req(cpu_irq_req),
    .raw_irq(raw_irq));
  cpu_core_model core (.mclk(mclk), .rst_n(rst_n),
    .cpu_irq_req(cpu_irq_req), .irq_taken_q(irq_taken_q));
  // Compare one value
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle write, toggling event lines e alongside
  task automatic wr(input logic [8:0] a, input logic [7:0] d,
                    input logic [7:0] e);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    ev <= ev ^ e;
    @(posedge mclk);
    reg_wr <= 1'b0;
    ev <= ev ^ e;
  endtask
  // One-cycle read, expected data noted for the monitor
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  // Request level as the core saw it
  task automatic chk_irq(input logic e);
    @(posedge mclk);
    #1 check({7'h00, irq_taken_q}, {7'h00, e});
  endtask
  // Raw interrupt level, settled from the last edge
  task automatic chk_raw(input logic e);
    @(posedge mclk);
    check({7'h00, raw_irq}, {7'h00, e});
  endtask
  // Read data arrive the cycle after the strobe
  always @(posedge mclk) begin
    if (rd_seen)
      check(reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
  end
  // Closing summary and verdict
  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (3000) @(posedge mclk);
    n_mismatch++;
    print_verdict;
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(irq_flags_pkg::OFF_EN_PRI, 8'h00);
    rd(irq_flags_pkg::OFF_FLAG_PRI, 8'h00);
    rd(irq_flags_pkg::OFF_EN_SEC, 8'h80);
    rd(irq_flags_pkg::OFF_OPTION, 8'h00);
    rd(9'h100, 8'h00);
    r = 8'($random(seed));
    wr(irq_flags_pkg::OFF_EN_PRI, r, 8'h00);
    rd(irq_flags_pkg::OFF_EN_PRI, r);
    check({7'h00, wake_timer_run}, {7'h00, r[3]});
    wr(irq_flags_pkg::OFF_EN_PRI, 8'hff, 8'h00);
    // Each primary source with a write of ones on the same edge
    for (int i = 7; i >= 0; i--) begin
      wr(irq_flags_pkg::OFF_FLAG_PRI, 8'hff, 8'h01 << i);
      if (i < 3)
        repeat (4) @(posedge mclk);
      rd(irq_flags_pkg::OFF_FLAG_PRI, 8'h01 << i);
      chk_irq(1'b1);
      wr(irq_flags_pkg::OFF_FLAG_PRI, 8'h00, 8'h00);
    end
    chk_irq(1'b0);
    wr(irq_flags_pkg::OFF_FLAG_PRI, 8'h00, 8'h80);
    rd(irq_flags_pkg::OFF_FLAG_PRI, 8'h80);
    wr(irq_flags_pkg::OFF_FLAG_PRI, 8'h00, 8'h00);
    // Rising polarity on pins zero and one
    wr(irq_flags_pkg::OFF_OPTION, 8'h60, 8'h00);
    rd(irq_flags_pkg::OFF_OPTION, 8'h60);
    ev[1:0] <= 2'b00;
    repeat (5) @(posedge mclk);
    rd(irq_flags_pkg::OFF_FLAG_PRI, 8'h00);
    ev[1:0] <= 2'b11;
    repeat (5) @(posedge mclk);
    rd(irq_flags_pkg::OFF_FLAG_PRI, 8'h03);
    wr(irq_flags_pkg::OFF_FLAG_PRI, 8'h00, 8'h00);
    rd(irq_flags_pkg::OFF_FLAG_PRI, 8'h00);
    // Secondary sources, global gate, read-only serial flag
    wr(irq_flags_pkg::OFF_EN_SEC, 8'hc3, 8'h00);
    for (int j = 0; j < 4; j++) begin
      sv <= 4'h1 << j;
      rd(irq_flags_pkg::OFF_FLAG_SEC, j < 2 ? 8'h01 << j : 8'h40);
      chk_irq(1'b1);
      wr(irq_flags_pkg::OFF_EN_SEC, 8'h43, 8'h00);
      chk_irq(1'b0);
      wr(irq_flags_pkg::OFF_EN_SEC, 8'hc3, 8'h00);
      sv <= 4'h0;
      wr(irq_flags_pkg::OFF_FLAG_SEC, 8'h00, 8'h00);
      rd(irq_flags_pkg::OFF_FLAG_SEC, 8'h00);
    end
    // Raw sticky status and its mask
    wr(irq_flags_pkg::OFF_RAW_MASK, 8'h80, 8'h00);
    chk_raw(1'b1);
    wr(irq_flags_pkg::OFF_RAW_STAT, 8'hff, 8'h00);
    chk_raw(1'b0);
    rd(irq_flags_pkg::OFF_RAW_STAT, 8'h00);
    wr(irq_flags_pkg::OFF_RAW_STAT, 8'h00, 8'h80);
    rd(irq_flags_pkg::OFF_RAW_STAT, 8'h80);
    chk_raw(1'b1);
    repeat (2) @(posedge mclk);
    print_verdict;
  end
endmodule // tb_interrupt_enable_flag_logic
